// ==== include/ctc_pkg.sv ====
// Constants, register map and types of the commissioning test controller
package ctc_pkg;
	localparam int OPTO_W = 32;
	localparam int RELAY_W = 32;
	localparam int LED_W = 8;
	localparam int BUS_W = 256;
	localparam int SEL_W = 8;
	localparam int PROBES = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	localparam logic [ADDR_W-1:0] OFS_MODE_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MODE_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_OPTO_STATE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RELAY_STATE = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CONTACT_MASK = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CONTACT_CMD = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_LAMP_CMD = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_RED_STATE = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_GREEN_STATE = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_YELLOW_STATE = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_PROBE_STATE = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_PROBE_SEL_LO = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_PROBE_SEL_HI = 8'h30;

	localparam logic [1:0] SEL_DISABLED = 2'h0;
	localparam logic [1:0] SEL_TEST = 2'h1;
	localparam logic [1:0] SEL_INHIBIT = 2'h2;

	localparam logic [1:0] CMD_NOOP = 2'h0;
	localparam logic [1:0] CMD_APPLY = 2'h1;
	localparam logic [1:0] CMD_CLEAR = 2'h2;

	localparam int STAT_OOS_BIT = 2;
	localparam int STAT_CAUSE_BIT = 3;
	localparam int STAT_FREEZE_BIT = 4;
	localparam int CMD_ACTIVE_BIT = 8;

	localparam logic [1:0] MODE_CTRL_RESET = 2'h0;
	localparam logic [RELAY_W-1:0] CONTACT_MASK_RESET = 32'h0000_0000;
	localparam logic [SEL_W-1:0] PROBE_SEL_RESET = 8'h00;

	localparam int CLK_HZ = 25_000_000;
	localparam int LAMP_TEST_MS = 2000;
	localparam int LAMP_TEST_CYCLES = LAMP_TEST_MS * (CLK_HZ / 1000);
	localparam int LAMP_CNT_W = 26;

	typedef enum logic [1:0] {
		ST_IN_SERVICE,
		ST_TEST,
		ST_INHIBIT
	} ctc_mode_t;
endpackage : ctc_pkg

// ==== logic/ctc_top.sv ====
// Commissioning test controller with APB register slave
`timescale 1ns/1ps

module ctc_top #(
	parameter int LAMP_CYCLES = ctc_pkg::LAMP_TEST_CYCLES
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ctc_pkg::ADDR_W-1:0] paddr,
	input wire logic [ctc_pkg::DATA_W-1:0] pwdata,
	output logic [ctc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [ctc_pkg::OPTO_W-1:0] opto_in,
	input wire logic [ctc_pkg::RELAY_W-1:0] scheme_relay_req,
	input wire logic scheme_test_req,
	input wire logic scheme_inhibit_req,
	input wire logic [ctc_pkg::LED_W-1:0] scheme_red_req,
	input wire logic [ctc_pkg::LED_W-1:0] scheme_green_req,
	input wire logic [ctc_pkg::BUS_W-1:0] internal_signal_bus,
	output logic [ctc_pkg::RELAY_W-1:0] relay_drive,
	output logic [ctc_pkg::LED_W-1:0] led_red,
	output logic [ctc_pkg::LED_W-1:0] led_green,
	output logic out_of_service_led,
	output logic alarm_event,
	output logic breaker_wear_freeze,
	output logic transmission_cause_test,
	output logic [ctc_pkg::PROBES-1:0] monitor_pin
);
	import ctc_pkg::*;

	logic [OPTO_W-1:0] opto_meta_reg;
	logic [OPTO_W-1:0] opto_sync_reg;
	logic [1:0] mode_sel_reg;
	ctc_mode_t mode_reg;
	ctc_mode_t mode_next;
	logic [RELAY_W-1:0] contact_mask_reg;
	logic contact_test_reg;
	logic lamp_busy_reg;
	logic [LAMP_CNT_W-1:0] lamp_cnt_reg;
	logic [SEL_W-1:0] probe_sel_reg [PROBES];
	logic [PROBES-1:0] probe_live;
	logic [PROBES-1:0] probe_state_reg;
	logic [RELAY_W-1:0] drive_next;
	logic [RELAY_W-1:0] would_next;
	logic [RELAY_W-1:0] relay_state_reg;
	logic [LED_W-1:0] red_next;
	logic [LED_W-1:0] green_next;
	logic wr_en;
	logic rd_setup;
	logic [DATA_W-1:0] rd_data;
	logic rd_err;

	localparam logic [LAMP_CNT_W-1:0] LAMP_LAST = LAMP_CNT_W'(LAMP_CYCLES - 1);

	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	// Zero wait states: read data is latched in the setup cycle
	assign pready = 1'b1;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			opto_meta_reg <= '0;
			opto_sync_reg <= '0;
		end else begin
			opto_meta_reg <= opto_in;
			opto_sync_reg <= opto_meta_reg;
		end
	end

	// Mode selection register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_sel_reg <= MODE_CTRL_RESET;
		end else if (wr_en && paddr == OFS_MODE_CTRL) begin
			mode_sel_reg <= pwdata[1:0];
		end
	end

	// Mapped opto signals merged with selection
	always_comb begin
		mode_next = ST_IN_SERVICE;
		if (mode_sel_reg == SEL_INHIBIT || scheme_inhibit_req) begin
			mode_next = ST_INHIBIT;
		end else if (mode_sel_reg == SEL_TEST || scheme_test_req) begin
			mode_next = ST_TEST;
		end
	end

	// Mode machine, disabled returns to service
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg <= ST_IN_SERVICE;
		end else begin
			case (mode_reg)
				ST_IN_SERVICE: mode_reg <= mode_next;
				ST_TEST: mode_reg <= mode_next;
				ST_INHIBIT: mode_reg <= mode_next;
				default: mode_reg <= ST_IN_SERVICE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			alarm_event <= 1'b0;
		end else begin
			alarm_event <= (mode_reg == ST_IN_SERVICE) && (mode_next != ST_IN_SERVICE);
		end
	end

	// Indicator, from mode_next so it moves with mode_reg
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_of_service_led <= 1'b0;
		end else begin
			out_of_service_led <= mode_next != ST_IN_SERVICE;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			breaker_wear_freeze <= 1'b0;
		end else begin
			breaker_wear_freeze <= mode_next != ST_IN_SERVICE;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			transmission_cause_test <= 1'b0;
		end else begin
			transmission_cause_test <= mode_next != ST_IN_SERVICE;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			contact_mask_reg <= CONTACT_MASK_RESET;
		end else if (wr_en && paddr == OFS_CONTACT_MASK) begin
			contact_mask_reg <= pwdata[RELAY_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			contact_test_reg <= 1'b0;
		end else if (wr_en && paddr == OFS_CONTACT_CMD) begin
			if (pwdata[1:0] == CMD_APPLY) begin
				contact_test_reg <= 1'b1;
			end else if (pwdata[1:0] == CMD_CLEAR) begin
				contact_test_reg <= 1'b0;
			end
		end
	end

	// Contact test forces selected contacts on
	always_comb begin
		would_next = scheme_relay_req;
		if (contact_test_reg) begin
			would_next = scheme_relay_req | contact_mask_reg;
		end
	end

	always_comb begin
		drive_next = would_next;
		if (mode_reg == ST_INHIBIT) begin
			drive_next = '0;
		end
	end

	// Scheme logic still drives in test
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			relay_drive <= '0;
			relay_state_reg <= '0;
		end else begin
			relay_drive <= drive_next;
			if (mode_reg == ST_INHIBIT) begin
				// Includes a running contact test, as service would
				relay_state_reg <= would_next;
			end else begin
				relay_state_reg <= drive_next;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			lamp_busy_reg <= 1'b0;
			lamp_cnt_reg <= '0;
		end else if (lamp_busy_reg) begin
			if (lamp_cnt_reg == LAMP_LAST) begin
				lamp_busy_reg <= 1'b0;
				lamp_cnt_reg <= '0;
			end else begin
				lamp_cnt_reg <= lamp_cnt_reg + 1'b1;
			end
		end else if (wr_en && paddr == OFS_LAMP_CMD && pwdata[0]) begin
			lamp_busy_reg <= 1'b1;
			lamp_cnt_reg <= '0;
		end
	end

	// All red and green LEDs lit during lamp test
	assign red_next = lamp_busy_reg ? '1 : scheme_red_req;
	assign green_next = lamp_busy_reg ? '1 : scheme_green_req;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			led_red <= '0;
			led_green <= '0;
		end else begin
			led_red <= red_next;
			led_green <= green_next;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < PROBES; i++) begin
				probe_sel_reg[i] <= PROBE_SEL_RESET;
			end
		end else if (wr_en && paddr == OFS_PROBE_SEL_LO) begin
			for (int i = 0; i < 4; i++) begin
				probe_sel_reg[i] <= pwdata[i*SEL_W +: SEL_W];
			end
		end else if (wr_en && paddr == OFS_PROBE_SEL_HI) begin
			for (int i = 0; i < 4; i++) begin
				probe_sel_reg[i+4] <= pwdata[i*SEL_W +: SEL_W];
			end
		end
	end

	// Live bit picked by each selector
	always_comb begin
		probe_live = '0;
		for (int i = 0; i < PROBES; i++) begin
			probe_live[i] = internal_signal_bus[probe_sel_reg[i]];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			probe_state_reg <= '0;
			monitor_pin <= '0;
		end else begin
			probe_state_reg <= probe_live;
			monitor_pin <= probe_live;
		end
	end

	// Read decode; unmapped offsets answer with an error
	always_comb begin
		rd_data = '0;
		rd_err = 1'b0;
		if (paddr == OFS_MODE_CTRL) begin
			rd_data[1:0] = mode_sel_reg;
		end else if (paddr == OFS_MODE_STAT) begin
			rd_data[1:0] = mode_reg;
			rd_data[STAT_OOS_BIT] = out_of_service_led;
			rd_data[STAT_CAUSE_BIT] = transmission_cause_test;
			rd_data[STAT_FREEZE_BIT] = breaker_wear_freeze;
		end else if (paddr == OFS_OPTO_STATE) begin
			rd_data[OPTO_W-1:0] = opto_sync_reg;
		end else if (paddr == OFS_RELAY_STATE) begin
			rd_data[RELAY_W-1:0] = relay_state_reg;
		end else if (paddr == OFS_CONTACT_MASK) begin
			rd_data[RELAY_W-1:0] = contact_mask_reg;
		end else if (paddr == OFS_CONTACT_CMD) begin
			rd_data[1:0] = CMD_NOOP;
			rd_data[CMD_ACTIVE_BIT] = contact_test_reg;
		end else if (paddr == OFS_LAMP_CMD) begin
			rd_data[0] = lamp_busy_reg;
		end else if (paddr == OFS_RED_STATE) begin
			rd_data[LED_W-1:0] = led_red;
		end else if (paddr == OFS_GREEN_STATE) begin
			rd_data[LED_W-1:0] = led_green;
		end else if (paddr == OFS_YELLOW_STATE) begin
			rd_data[LED_W-1:0] = led_red & led_green;
		end else if (paddr == OFS_PROBE_STATE) begin
			rd_data[PROBES-1:0] = probe_state_reg;
		end else if (paddr == OFS_PROBE_SEL_LO) begin
			for (int i = 0; i < 4; i++) begin
				rd_data[i*SEL_W +: SEL_W] = probe_sel_reg[i];
			end
		end else if (paddr == OFS_PROBE_SEL_HI) begin
			for (int i = 0; i < 4; i++) begin
				rd_data[i*SEL_W +: SEL_W] = probe_sel_reg[i+4];
			end
		end else begin
			rd_err = 1'b1;
		end
	end

	// Answer registered in setup so the access phase sees stable data
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (rd_setup) begin
			prdata <= pwrite ? '0 : rd_data;
			pslverr <= rd_err;
		end else if (!psel) begin
			pslverr <= 1'b0;
		end
	end
endmodule : ctc_top

// ==== verification/commissioning_test_control_test.sv ====
// Self-checking bench of the commissioning test controller
`timescale 1ns/1ps
module commissioning_test_control_test;
	import ctc_pkg::*;
	localparam int LC = 20;
	logic core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic test_req = 1'b0, inh_req = 1'b0, oos, alarm, frz, cause;
	logic [7:0] paddr = 8'h00, red, green, lr, lg, mon;
	logic [31:0] pwdata = 32'h0, opto_in = 32'h0, pat = 32'h0, lfsr = 32'h0001_84DF, prdata, rly, rd, m_r, m_s;
	logic [255:0] bus;
	logic [31:0] rq;
	int n_errors = 0, total_checks = 0, n_alarm = 0;
	logic [1:0] modes [4] = '{SEL_TEST, SEL_INHIBIT, 2'h3, SEL_DISABLED};
	always #20 core_clk = ~core_clk;
	// Alarm is a one-cycle pulse, so it is counted at every edge
	always @(posedge core_clk) begin
		if (alarm === 1'b1) n_alarm <= n_alarm + 1;
	end
	ctc_far_model i_far (.core_clk(core_clk), .arst_n(arst_n), .pattern(pat), .scheme_relay_req(rq),
		.scheme_red_req(red), .scheme_green_req(green), .internal_signal_bus(bus));
	ctc_top #(.LAMP_CYCLES(LC)) i_dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.opto_in(opto_in), .scheme_relay_req(rq), .scheme_test_req(test_req), .scheme_inhibit_req(inh_req),
		.scheme_red_req(red), .scheme_green_req(green), .internal_signal_bus(bus), .relay_drive(rly),
		.led_red(lr), .led_green(lg), .out_of_service_led(oos), .alarm_event(alarm), .breaker_wear_freeze(frz),
		.transmission_cause_test(cause), .monitor_pin(mon));
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	function automatic logic [31:0] exp_stat(logic [1:0] m);
		logic [1:0] e = (m == 2'h3) ? 2'h0 : m;
		return {27'h0, {3{e != 2'h0}}, e};
	endfunction : exp_stat
	function automatic logic [7:0] exp_probe(logic [63:0] sel, logic [31:0] p);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = p[sel[8*i +: 5]];
		return r;
	endfunction : exp_probe
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rdc
	// Outputs are looked at mid-cycle, clear of edge updates
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : settle
	task print_verdict();
		$display("mismatches %0d comparisons %0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		rdc(OFS_MODE_CTRL, {30'h0, MODE_CTRL_RESET}, "mode_rst");
		rdc(OFS_CONTACT_MASK, CONTACT_MASK_RESET, "mask_rst");
		rdc(OFS_PROBE_SEL_HI, 32'h0, "sel_rst");
		apb(1'b1, OFS_MODE_STAT, 32'h1F);
		rdc(OFS_MODE_STAT, 32'h0, "stat_ro");
		apb(1'b1, 8'hFC, rnd());
		chk("unmapped_wr", 32'h1, {31'h0, err});
		rdc(8'hFC, 32'h0, "unmapped_data");
		chk("unmapped_rd", 32'h1, {31'h0, err});
		@(posedge core_clk);
		opto_in <= rnd();
		pat <= rnd();
		settle(4);
		rdc(OFS_OPTO_STATE, opto_in, "opto");
		chk("drive_service", pat, rly);
		foreach (modes[i]) begin
			apb(1'b1, OFS_MODE_CTRL, {30'h0, modes[i]});
			settle(2);
			chk("drive_mode", (modes[i] == SEL_INHIBIT) ? 32'h0 : pat, rly);
			chk("oos", (exp_stat(modes[i]) & 32'h4) ? 32'h7 : 32'h0, {29'h0, oos, frz, cause});
			apb(1'b0, OFS_MODE_STAT, 32'h0);
			chk("mode_stat", exp_stat(modes[i]), rd & 32'h1F);
			rdc(OFS_RELAY_STATE, pat, "relay_state");
		end
		@(posedge core_clk);
		test_req <= 1'b1;
		settle(2);
		chk("pin_test", pat, rly);
		chk("pin_test_oos", 32'h1, {31'h0, oos});
		@(posedge core_clk);
		inh_req <= 1'b1;
		settle(2);
		chk("pin_inhibit", 32'h0, rly);
		@(posedge core_clk);
		test_req <= 1'b0;
		inh_req <= 1'b0;
		settle(2);
		chk("pin_release", 32'h0, {31'h0, oos});
		m_r = rnd();
		apb(1'b1, OFS_CONTACT_MASK, m_r);
		rdc(OFS_CONTACT_MASK, m_r, "mask");
		apb(1'b1, OFS_CONTACT_CMD, {30'h0, CMD_APPLY});
		settle(1);
		chk("contact_apply", pat | m_r, rly);
		apb(1'b0, OFS_CONTACT_CMD, 32'h0);
		chk("cmd_apply_rd", 32'h1 << CMD_ACTIVE_BIT, rd & 32'h103);
		apb(1'b1, OFS_MODE_CTRL, {30'h0, SEL_INHIBIT});
		settle(2);
		chk("contact_inhibit", 32'h0, rly);
		rdc(OFS_RELAY_STATE, pat | m_r, "relay_state_inh");
		apb(1'b1, OFS_MODE_CTRL, {30'h0, SEL_DISABLED});
		apb(1'b1, OFS_CONTACT_CMD, {30'h0, CMD_CLEAR});
		settle(2);
		chk("contact_clear", pat, rly);
		chk("alarm_count", 32'd3, n_alarm);
		apb(1'b0, OFS_CONTACT_CMD, 32'h0);
		chk("cmd_clear_rd", 32'h0, rd & 32'h103);
		apb(1'b1, OFS_LAMP_CMD, 32'h1);
		settle(1);
		chk("lamp_on", 32'hFFFF, {16'h0, lg, lr});
		rdc(OFS_YELLOW_STATE, 32'hFF, "yellow_lamp");
		// Lamp check and yellow read took four edges; this is the last lit cycle
		settle(LC - 4);
		chk("lamp_hold", 32'hFFFF, {16'h0, lg, lr});
		settle(1);
		chk("lamp_off", {16'h0, pat[15:0]}, {16'h0, lg, lr});
		apb(1'b0, OFS_LAMP_CMD, 32'h0);
		chk("lamp_cmd", 32'h0, rd & 32'h1);
		rdc(OFS_RED_STATE, {24'h0, pat[7:0]}, "red");
		rdc(OFS_GREEN_STATE, {24'h0, pat[15:8]}, "green");
		rdc(OFS_YELLOW_STATE, {24'h0, pat[7:0] & pat[15:8]}, "yellow");
		repeat (3) begin
			@(posedge core_clk);
			pat <= rnd();
			m_r = rnd();
			m_s = rnd();
			apb(1'b1, OFS_PROBE_SEL_LO, m_r);
			apb(1'b1, OFS_PROBE_SEL_HI, m_s);
			settle(2);
			chk("monitor", {24'h0, exp_probe({m_s, m_r}, pat)}, {24'h0, mon});
			rdc(OFS_PROBE_STATE, {24'h0, exp_probe({m_s, m_r}, pat)}, "probe_state");
			rdc(OFS_PROBE_SEL_HI, m_s, "probe_sel");
		end
		// Mid-run reset clears outputs and settings
		@(posedge core_clk);
		arst_n <= 1'b0;
		settle(2);
		chk("reset_drive", 32'h0, rly);
		chk("reset_outputs", 32'h0, {7'h0, oos, lr, lg, mon});
		@(posedge core_clk);
		arst_n <= 1'b1;
		rdc(OFS_PROBE_SEL_LO, 32'h0, "sel_mid_rst");
		rdc(OFS_CONTACT_MASK, CONTACT_MASK_RESET, "mask_mid_rst");
		chk("drive_after_reset", pat, rly);
		print_verdict();
	end
endmodule : commissioning_test_control_test

// ==== verification/ctc_far_model.sv ====
// Far-side model: scheme logic requests and internal signal bus
`timescale 1ns/1ps
module ctc_far_model (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [31:0] pattern,
	output logic [ctc_pkg::RELAY_W-1:0] scheme_relay_req,
	output logic [ctc_pkg::LED_W-1:0] scheme_red_req,
	output logic [ctc_pkg::LED_W-1:0] scheme_green_req,
	output logic [ctc_pkg::BUS_W-1:0] internal_signal_bus
);
	import ctc_pkg::*;
	// Bus repeats the pattern, so any index maps to pattern bit mod 32
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			scheme_relay_req <= '0;
			scheme_red_req <= '0;
			scheme_green_req <= '0;
			internal_signal_bus <= '0;
		end else begin
			scheme_relay_req <= pattern;
			scheme_red_req <= pattern[7:0];
			scheme_green_req <= pattern[15:8];
			internal_signal_bus <= {8{pattern}};
		end
	end
endmodule : ctc_far_model

// ==== verification/ctc_top_sva.sv ====
// Port-level assertion checker for the commissioning test controller
`timescale 1ns/1ps
module ctc_top_sva #(
	parameter int LAMP_CYCLES = 20
) (
	input logic core_clk,
	input logic arst_n,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [ctc_pkg::ADDR_W-1:0] paddr,
	input logic [ctc_pkg::DATA_W-1:0] pwdata,
	input logic [ctc_pkg::DATA_W-1:0] prdata,
	input logic pready,
	input logic pslverr,
	input logic scheme_test_req,
	input logic scheme_inhibit_req,
	input logic [ctc_pkg::RELAY_W-1:0] relay_drive,
	input logic [ctc_pkg::LED_W-1:0] led_red,
	input logic [ctc_pkg::LED_W-1:0] led_green,
	input logic out_of_service_led,
	input logic alarm_event,
	input logic breaker_wear_freeze,
	input logic transmission_cause_test
);
	import ctc_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	// Start only while idle: a busy lamp test ignores the write
	sequence s_lamp_go;
		psel && penable && pwrite && paddr == OFS_LAMP_CMD && pwdata[0] && !(led_red == '1 && led_green == '1);
	endsequence
	sequence s_lit;
		(led_red == '1 && led_green == '1) [*8];
	endsequence
	property p_lamp; s_lamp_go |=> ##1 s_lit; endproperty
	a_lamp: assert property (p_lamp) else $error("lamp test not lit");
	property p_inhibit; scheme_inhibit_req [*2] |=> relay_drive == '0; endproperty
	a_inhibit: assert property (p_inhibit) else $error("drive not blocked");
	property p_alarm; alarm_event == $rose(out_of_service_led); endproperty
	a_alarm: assert property (p_alarm) else $error("alarm not tied to leaving service");
	property p_pulse; alarm_event |=> !alarm_event; endproperty
	a_pulse: assert property (p_pulse) else $error("alarm longer than one cycle");
	property p_freeze; breaker_wear_freeze == out_of_service_led; endproperty
	a_freeze: assert property (p_freeze) else $error("wear record freeze wrong");
	property p_cause; transmission_cause_test == out_of_service_led; endproperty
	a_cause: assert property (p_cause) else $error("transmission cause wrong");
	property p_pin_req; scheme_test_req || scheme_inhibit_req |=> out_of_service_led; endproperty
	a_pin_req: assert property (p_pin_req) else $error("mapped input ignored");
	property p_decode;
		psel && !penable |=> pslverr == !($past(paddr) <= OFS_PROBE_SEL_HI && $past(paddr) % 4 == 0)
			&& (!pslverr || prdata == '0);
	endproperty
	a_decode: assert property (p_decode) else $error("address decode error flag wrong");
	property p_err_clr; !psel |=> !pslverr; endproperty
	a_err_clr: assert property (p_err_clr) else $error("error flag held while idle");
endmodule : ctc_top_sva

bind ctc_top ctc_top_sva #(.LAMP_CYCLES(LAMP_CYCLES)) i_sva (.core_clk, .arst_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .scheme_test_req, .scheme_inhibit_req, .relay_drive,
	.led_red, .led_green, .out_of_service_led, .alarm_event, .breaker_wear_freeze, .transmission_cause_test);
